// File: shared/srw_pkg.sv
// Purpose: constants for the supervisor reset and watchdog block
// Assumes: 100 MHz clock
// Notes:   times kept in their own units, cycle counts derived
package srw_pkg;
   localparam int unsigned CLK_MHZ       = 100;
   localparam int unsigned RST_TIMEOUT_MS = 200;
   localparam int unsigned WDOG_PERIOD_MS = 1600;
   localparam int unsigned DEBOUNCE_US    = 10;
   localparam int unsigned RST_TIMEOUT_CYC = RST_TIMEOUT_MS * 1000 * CLK_MHZ;
   localparam int unsigned WDOG_PERIOD_CYC = WDOG_PERIOD_MS * 1000 * CLK_MHZ;
   localparam int unsigned DEBOUNCE_CYC    = DEBOUNCE_US * CLK_MHZ;
   localparam int unsigned CNT_W           = 28;
   // variant codes
   localparam logic [1:0] VAR_WP_SDA  = 2'h0;
   localparam logic [1:0] VAR_LOW_SDA = 2'h1;
   localparam logic [1:0] VAR_KICK    = 2'h2;
endpackage

// File: logic/srw_debounce.sv
// Purpose: debounce filter for the manual reset input
// Assumes: input synchronous to clock
// Notes:   output follows only after the input is stable for STABLE_CYC
`timescale 1ns/1ns
module srw_debounce #(
   parameter int unsigned STABLE_CYC = 1000,
   parameter int unsigned CW         = 16
) (
   // clock and reset
   input  wire logic clock,
   input  wire logic rst,
   // raw and filtered level
   input  wire logic raw_in,
   output logic      clean_out
);
   logic [CW-1:0] cnt_q;
   logic          clean_q;
   wire           differs = raw_in != clean_q;
   wire           settled = cnt_q >= CW'(STABLE_CYC - 1);

   always_ff @(posedge clock) begin
      if (rst) begin
         cnt_q   <= '0;
         clean_q <= 1'b1;
      end else if (!differs) begin
         cnt_q <= '0;
      end else if (settled) begin
         cnt_q   <= '0;
         clean_q <= raw_in;
      end else begin
         cnt_q <= cnt_q + 1'b1;
      end
   end
   assign clean_out = clean_q;

   chk_glitch_blocked: assert property (@(posedge clock) disable iff (rst)
      (differs && !settled) |=> $stable(clean_q))
      else $error("debounce output moved before input settled");
endmodule // srw_debounce

// File: logic/srw_supervisor.sv
// Purpose: supervisory reset sequencer with watchdog and write gating
// Assumes: supply-low flag comes from an analog comparator, synchronous
// Notes:   counts are parameters so simulation can shorten them
// How it works
// - while supply is low both reset outputs, or in the low-only variant the active-low one, are asserted through open-drain drives.
// - after supply returns the outputs stay asserted for the reset timeout.
// - the watchdog resets the system if not restarted within its period.
// - in the kick variant any edge on the kick input restarts the watchdog.
// - otherwise any edge on the serial data line restarts the watchdog.
// - the manual reset input is debounced before use.
// - a low manual reset holds reset, then the full timeout follows its release.
// - an external low on the active-low reset pin starts a reset; once the pin is driven it is masked and the timeout runs.
// - write protect low allows writes to the whole array.
// - in the protect variant only, write protect high blocks every write.
// - writes are inhibited whenever supply is low, including power-up.
// - the low-only variant has no active-high output and no write protect.
`timescale 1ns/1ns
module srw_supervisor #(
   parameter logic [1:0]  VARIANT     = srw_pkg::VAR_WP_SDA,
   parameter int unsigned RST_CYC     = srw_pkg::RST_TIMEOUT_CYC,
   parameter int unsigned WDOG_CYC    = srw_pkg::WDOG_PERIOD_CYC,
   parameter int unsigned DEBOUNCE_CY = srw_pkg::DEBOUNCE_CYC
) (
   // clock and reset
   input  wire logic clock,
   input  wire logic rst,
   // supply monitor
   input  wire logic supply_low,
   // host side inputs
   input  wire logic manual_reset_in_n,
   input  wire logic watchdog_kick_in,
   input  wire logic sda_in,
   input  wire logic write_protect_in,
   // active-low reset pin, open drain
   input  wire logic reset_n_in,
   output logic      reset_n_out,
   output logic      reset_n_oe,
   // active-high reset pin, open drain pulling high
   output logic      reset_hi_out,
   output logic      reset_hi_oe,
   // memory write gate
   input  wire logic write_req,
   output logic      write_allow
);
   localparam int unsigned CW = srw_pkg::CNT_W;

   typedef enum logic [1:0] {SRW_HOLD, SRW_TIMEOUT, SRW_RUN} srw_state_e;

   // =====================================================
   // inputs
   logic mr_clean;
   srw_debounce #(.STABLE_CYC(DEBOUNCE_CY), .CW(CW)) u_mr_deb (
      .clock     (clock),
      .rst       (rst),
      .raw_in    (manual_reset_in_n),
      .clean_out (mr_clean)
   );

   logic mon_prev_q;
   wire  use_kick = VARIANT == srw_pkg::VAR_KICK;
   wire  mon_sig  = use_kick ? watchdog_kick_in : sda_in;
   wire  kick     = mon_sig != mon_prev_q;

   // own drive excluded: only an outside low counts
   wire  ext_low  = !reset_n_in && !reset_n_oe;
   wire  hold     = supply_low || !mr_clean || ext_low;

   // =====================================================
   // sequencer
   srw_state_e    st_q, st_d;
   logic [CW-1:0] tmo_q, tmo_d;
   logic [CW-1:0] wd_q,  wd_d;
   wire           tmo_done = tmo_q >= CW'(RST_CYC - 1);
   wire           wd_done  = wd_q  >= CW'(WDOG_CYC - 1);

   always_comb begin
      st_d  = st_q;
      tmo_d = '0;
      wd_d  = '0;
      case (st_q)
         SRW_HOLD: begin
            if (!hold) begin
               st_d = SRW_TIMEOUT;
            end
         end
         SRW_TIMEOUT: begin
            if (hold) begin
               st_d = SRW_HOLD;
            end else if (tmo_done) begin
               st_d = SRW_RUN;
            end else begin
               tmo_d = tmo_q + 1'b1;
            end
         end
         SRW_RUN: begin
            if (hold) begin
               st_d = SRW_HOLD;
            end else if (wd_done && !kick) begin
               st_d = SRW_TIMEOUT;
            end else if (!kick) begin
               wd_d = wd_q + 1'b1;
            end
         end
         default: st_d = SRW_HOLD;
      endcase
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         st_q       <= SRW_HOLD;
         tmo_q      <= '0;
         wd_q       <= '0;
         // follow the pin so no false edge shows right after reset
         mon_prev_q <= mon_sig;
      end else begin
         st_q       <= st_d;
         tmo_q      <= tmo_d;
         wd_q       <= wd_d;
         mon_prev_q <= mon_sig;
      end
   end

   // =====================================================
   // outputs
   logic rst_act_q;
   logic wr_q;
   wire  has_hi = VARIANT != srw_pkg::VAR_LOW_SDA;
   wire  has_wp = VARIANT == srw_pkg::VAR_WP_SDA;
   wire  wp_ok  = !has_wp || !write_protect_in;

   always_ff @(posedge clock) begin
      if (rst) begin
         rst_act_q <= 1'b1;
         wr_q      <= 1'b0;
      end else begin
         rst_act_q <= st_d != SRW_RUN;
         wr_q      <= write_req && wp_ok && !supply_low;
      end
   end

   assign reset_n_out  = 1'b0;
   assign reset_n_oe   = rst_act_q;
   assign reset_hi_out = 1'b1;
   assign reset_hi_oe  = rst_act_q && has_hi;
   assign write_allow  = wr_q;

   // =====================================================
   // checks
   chk_supply_holds: assert property (@(posedge clock) disable iff (rst)
      supply_low |=> reset_n_oe)
      else $error("reset released while supply low");
   chk_pins_together: assert property (@(posedge clock) disable iff (rst)
      has_hi |-> reset_n_oe == reset_hi_oe)
      else $error("reset pins disagree");
   chk_timeout_held: assert property (@(posedge clock) disable iff (rst)
      (st_q == SRW_TIMEOUT && !tmo_done) |=> reset_n_oe)
      else $error("reset released before timeout");
   chk_wdog_fires: assert property (@(posedge clock) disable iff (rst)
      (st_q == SRW_RUN && wd_done && !kick && !hold) |=> reset_n_oe)
      else $error("watchdog expiry did not reset");
   chk_kick_restarts: assert property (@(posedge clock) disable iff (rst)
      (st_q == SRW_RUN && kick) |=> wd_q == '0)
      else $error("kick did not restart watchdog");
   chk_mr_holds: assert property (@(posedge clock) disable iff (rst)
      !mr_clean |=> reset_n_oe)
      else $error("reset released while manual reset low");
   chk_ext_holds: assert property (@(posedge clock) disable iff (rst)
      ext_low |=> st_q == SRW_HOLD)
      else $error("external low did not hold reset");
   chk_wp_blocks: assert property (@(posedge clock) disable iff (rst)
      (has_wp && write_protect_in) |=> !write_allow)
      else $error("write passed with protect high");
   chk_supply_wr: assert property (@(posedge clock) disable iff (rst)
      supply_low |=> !write_allow)
      else $error("write passed with supply low");
   chk_lowonly: assert property (@(posedge clock) disable iff (rst)
      !has_hi |-> !reset_hi_oe)
      else $error("active-high pin driven in low-only variant");
   chk_wp_allows: assert property (@(posedge clock) disable iff (rst)
      (write_req && !write_protect_in && !supply_low) |=> write_allow)
      else $error("write refused with protect low");

   // the watchdog stays cleared outside run, so every release starts a full period
   chk_wd_restart: assert property (@(posedge clock) disable iff (rst)
      (st_q != SRW_RUN) |=> wd_q == '0)
      else $error("watchdog count kept outside run");
   chk_hold_enters: assert property (@(posedge clock) disable iff (rst)
      hold |=> st_q == SRW_HOLD)
      else $error("hold cause did not enter hold");
   chk_run_released: assert property (@(posedge clock) disable iff (rst)
      (st_q == SRW_RUN) |-> !reset_n_oe)
      else $error("reset still driven in run");

   cov_release: cover property (@(posedge clock) disable iff (rst)
      $fell(reset_n_oe));
   cov_kick: cover property (@(posedge clock) disable iff (rst)
      st_q == SRW_RUN && kick);
   cov_mr: cover property (@(posedge clock) disable iff (rst) !mr_clean);
   cov_wdog: cover property (@(posedge clock) disable iff (rst)
      st_q == SRW_RUN && wd_done && !kick);
   cov_ext: cover property (@(posedge clock) disable iff (rst) ext_low);
endmodule // srw_supervisor

// File: verif/srw_host_model.sv
// Purpose: host side model: reset wire with pull-up and bus activity
// Assumes: one clock shared with the supervisor
// Notes:   sda toggles every 20 cycles while kicking is enabled
`timescale 1ns/1ns
module srw_host_model (
   // clock
   input  wire logic clock,
   // bench controls
   input  wire logic kick_en,
   input  wire logic ext_low,
   // reset wire
   input  wire logic reset_n_oe,
   output logic      reset_n_wire,
   // bus activity
   output logic      sda
);
   logic [4:0] tick_q = 5'h00;
   initial sda = 1'b1;
   // wire is pulled up unless either party pulls it low
   assign reset_n_wire = !(reset_n_oe | ext_low);
   always @(posedge clock) begin
      tick_q <= (tick_q == 5'h13) ? 5'h00 : tick_q + 5'h01;
      if (kick_en && tick_q == 5'h13) begin
         sda <= !sda;
      end
   end
endmodule // srw_host_model

// File: verif/tb_supervisor_reset_watchdog.sv
// Purpose: self-checking bench for the supervisor
// Assumes: shortened counts, two-output protect variant
// Notes:   extra instances cover the kick and low-only variants
`timescale 1ns/1ns
module tb_supervisor_reset_watchdog;
   localparam int unsigned RST_C  = 50;
   localparam int unsigned WDOG_C = 200;
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic sup_lo = 1'b0;
   logic mr_n = 1'b1;
   logic wp = 1'b0;
   logic wreq = 1'b0;
   logic kick_en = 1'b1;
   logic ext_low = 1'b0;
   logic kick = 1'b0;
   logic k_oe, l_oe, l_hi_oe, l_allow;
   logic sda, rwire, n_oe, n_out, hi_out, hi_oe, allow;
   int   errors = 0;
   int   check_count = 0;
   always #5 clock = ~clock;
   srw_host_model host_u (.clock(clock), .kick_en(kick_en), .ext_low(ext_low),
      .reset_n_oe(n_oe), .reset_n_wire(rwire), .sda(sda));
   srw_supervisor #(.VARIANT(srw_pkg::VAR_WP_SDA), .RST_CYC(RST_C), .WDOG_CYC(WDOG_C),
      .DEBOUNCE_CY(4)) dut_u (.clock(clock), .rst(rst), .supply_low(sup_lo),
      .manual_reset_in_n(mr_n), .watchdog_kick_in(1'b0), .sda_in(sda),
      .write_protect_in(wp), .reset_n_in(rwire), .reset_n_out(n_out),
      .reset_n_oe(n_oe), .reset_hi_out(hi_out), .reset_hi_oe(hi_oe),
      .write_req(wreq), .write_allow(allow));
   srw_supervisor #(.VARIANT(srw_pkg::VAR_KICK), .RST_CYC(RST_C), .WDOG_CYC(WDOG_C),
      .DEBOUNCE_CY(4)) dut_k_u (.clock(clock), .rst(rst), .supply_low(1'b0),
      .manual_reset_in_n(1'b1), .watchdog_kick_in(kick), .sda_in(sda),
      .write_protect_in(1'b0), .reset_n_in(!k_oe), .reset_n_out(),
      .reset_n_oe(k_oe), .reset_hi_out(), .reset_hi_oe(),
      .write_req(1'b0), .write_allow());
   srw_supervisor #(.VARIANT(srw_pkg::VAR_LOW_SDA), .RST_CYC(RST_C), .WDOG_CYC(WDOG_C),
      .DEBOUNCE_CY(4)) dut_l_u (.clock(clock), .rst(rst), .supply_low(sup_lo),
      .manual_reset_in_n(mr_n), .watchdog_kick_in(1'b0), .sda_in(sda),
      .write_protect_in(wp), .reset_n_in(!l_oe), .reset_n_out(),
      .reset_n_oe(l_oe), .reset_hi_out(), .reset_hi_oe(l_hi_oe),
      .write_req(wreq), .write_allow(l_allow));
   task automatic conclude();
      if (errors == 0 && check_count > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // samples 1 ns after the edge so that edge's updates have landed
   task automatic check(input string what, input logic seen, input logic exp);
      check_count++;
      if (seen !== exp) begin
         errors++;
         $display("[ERR] %s expected %b seen %b", what, exp, seen);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask
   task automatic wait_oe(input logic exp, input int bound);
      for (int i = 0; i < bound; i++) begin
         cyc(1);
         if (n_oe === exp) return;
      end
      errors++;
      $display("[ERR] reset_n_oe expected %b seen %b", exp, n_oe);
      conclude();
   endtask
   task automatic supply_scn();
      @(posedge clock); sup_lo <= 1'b1; wreq <= 1'b1;
      cyc(2);
      check("reset_n_oe", n_oe, 1'b1);
      check("reset_hi_oe", hi_oe, 1'b1);
      check("write_allow", allow, 1'b0);
      check("low-only reset_n_oe", l_oe, 1'b1);
      check("low-only reset_hi_oe", l_hi_oe, 1'b0);
      @(posedge clock); sup_lo <= 1'b0;
      cyc(RST_C - 5);
      check("reset_n_oe", n_oe, 1'b1);
      check("write_allow", allow, 1'b1);
      wait_oe(1'b0, 10);
      check("reset_hi_oe", hi_oe, 1'b0);
      @(posedge clock); wp <= 1'b1;
      cyc(2);
      check("write_allow", allow, 1'b0);
      check("low-only write_allow", l_allow, 1'b1);
      @(posedge clock); wp <= 1'b0; wreq <= 1'b0;
   endtask
   task automatic mr_scn();
      @(posedge clock); mr_n <= 1'b0;
      cyc(2);
      @(posedge clock); mr_n <= 1'b1;
      cyc(8);
      check("reset_n_oe", n_oe, 1'b0);
      @(posedge clock); mr_n <= 1'b0;
      cyc(10);
      check("reset_n_oe", n_oe, 1'b1);
      @(posedge clock); mr_n <= 1'b1;
      cyc(RST_C);
      check("reset_n_oe", n_oe, 1'b1);
      wait_oe(1'b0, 15);
   endtask
   task automatic ext_scn();
      @(posedge clock); ext_low <= 1'b1;
      cyc(3);
      @(posedge clock); ext_low <= 1'b0;
      cyc(4);
      check("reset_n_oe", n_oe, 1'b1);
      wait_oe(1'b0, RST_C + 10);
   endtask
   // kick edges keep the kick variant alive; sda activity alone must not
   task automatic kick_scn();
      for (int i = 0; i < 300; i++) begin
         @(posedge clock);
         if (i % 20 == 0) kick <= !kick;
         #1;
         check("kick reset_n_oe", k_oe, 1'b0);
      end
      for (int i = 0; i < WDOG_C + 10 && k_oe !== 1'b1; i++) cyc(1);
      check("kick reset_n_oe", k_oe, 1'b1);
   endtask
   task automatic wdog_scn();
      for (int i = 0; i < 3 * WDOG_C; i++) begin
         cyc(1);
         check("reset_n_oe", n_oe, 1'b0);
      end
      @(posedge clock); kick_en <= 1'b0;
      cyc(WDOG_C - 25);
      check("reset_n_oe", n_oe, 1'b0);
      wait_oe(1'b1, 35);
      check("reset_hi_oe", hi_oe, 1'b1);
      wait_oe(1'b0, RST_C + 5);
      cyc(WDOG_C - 10);
      check("reset_n_oe", n_oe, 1'b0);
      wait_oe(1'b1, 20);
   endtask
   initial begin
      repeat (20) @(posedge clock);
      rst <= 1'b0;
      wait_oe(1'b0, RST_C + 10);
      kick_scn();
      supply_scn();
      mr_scn();
      ext_scn();
      wdog_scn();
      conclude();
   end
endmodule // tb_supervisor_reset_watchdog
